// File: verilog/ddrrt_defs.vh
// Constants for the read turnaround timing block
`ifndef DDRRT_DEFS_VH
`define DDRRT_DEFS_VH
`define DDRRT_CLK_PS 50000
`define DDRRT_RTP_MIN_NCK 4
`define DDRRT_RTP_MIN_PS 7500
`define DDRRT_RTP_NS_CYC ((`DDRRT_RTP_MIN_PS + `DDRRT_CLK_PS - 1) / `DDRRT_CLK_PS)
`define DDRRT_BL_FIX8 2'b00
`define DDRRT_BL_OTF 2'b01
`define DDRRT_BL_FIX4 2'b10
`define DDRRT_WR_001 3'b001
`define DDRRT_WR_001_NCK 6'h06
`define DDRRT_BEATS8 4'h8
`define DDRRT_BEATS4 4'h4
`define DDRRT_CMD_DES 3'h0
`define DDRRT_CMD_ACT 3'h1
`define DDRRT_CMD_RD 3'h2
`define DDRRT_CMD_WR 3'h3
`define DDRRT_CMD_PRE 3'h4
`define DDRRT_CNT_W 8
`endif

// File: verilog/ddrrt_delay.v
// Down counter that fires a one-cycle pulse after a programmed count
`include "ddrrt_defs.vh"
module ddrrt_delay (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_ce,
  input wire i_start,
  input wire [7:0] i_count,
  output reg o_fire,
  output wire o_busy
);
  reg [7:0] cnt_q;
  reg busy_q;
  assign o_busy = busy_q;
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q <= 8'h00;
      busy_q <= 1'b0;
      o_fire <= 1'b0;
    end else begin
      o_fire <= 1'b0;
      if (i_start) begin
        cnt_q <= i_count;
        busy_q <= 1'b1;
      end else if (busy_q && i_ce) begin
        if (cnt_q <= 8'h01) begin
          busy_q <= 1'b0;
          o_fire <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
    end
  end
endmodule

// File: verilog/ddrrt_core.v
// Read turnaround, burst mode and auto precharge timing of one DRAM bank
//==========================================================
// Overview of operation
// - The read-to-precharge delay is at least four clocks and 7.5 ns.
// - Mode 00, or mode 01 with A12 high, gives an 8-beat burst.
// - Mode 01 with A12 low gives a 4-beat chop per command.
// - Mode 10 forces every burst to a 4-beat chop.
// - Field bits 11 to 9 are the read-to-precharge code; every code, 001 included, gives six.
// - A10 high on READ precharges the bank after it, low keeps it open.
`include "ddrrt_defs.vh"
module ddrrt_core (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_ck,
  input wire [2:0] i_cmd,
  input wire i_a10,
  input wire i_a12,
  input wire [1:0] i_bl_mode,
  input wire [2:0] i_rtp_code,
  input wire [5:0] i_cl,
  input wire [5:0] i_cwl,
  input wire [5:0] i_al,
  input wire [7:0] i_tras,
  input wire [7:0] i_trp,
  input wire [7:0] i_trc,
  output reg o_bank_open,
  output reg o_precharging,
  output reg o_act_ok,
  output reg o_pre_ok,
  output reg o_rd_data_valid,
  output reg o_wr_data_expect,
  output reg o_burst_chop,
  output reg o_auto_pre
);
  //==========================================================
  // Link clock sampling
  reg [2:0] ck_sync_q;
  reg ck_lvl_q;
  wire ce;
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ck_sync_q <= 3'b000;
      ck_lvl_q <= 1'b0;
    end else begin
      ck_sync_q <= {ck_sync_q[1:0], i_ck};
      if (ck_sync_q[2] == ck_sync_q[1])
        ck_lvl_q <= ck_sync_q[2];
    end
  end
  assign ce = (ck_sync_q[2] == ck_sync_q[1]) && ck_sync_q[1] && !ck_lvl_q;
  //==========================================================
  // Command pin sampling
  reg [2:0] cmd_s0_q;
  reg [2:0] cmd_s1_q;
  reg [2:0] cmd_s2_q;
  reg [2:0] a10_sync_q;
  reg [2:0] a12_sync_q;
  wire pins_agree;
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cmd_s0_q <= `DDRRT_CMD_DES;
      cmd_s1_q <= `DDRRT_CMD_DES;
      cmd_s2_q <= `DDRRT_CMD_DES;
      a10_sync_q <= 3'b000;
      a12_sync_q <= 3'b000;
    end else begin
      cmd_s0_q <= i_cmd;
      cmd_s1_q <= cmd_s0_q;
      cmd_s2_q <= cmd_s1_q;
      a10_sync_q <= {a10_sync_q[1:0], i_a10};
      a12_sync_q <= {a12_sync_q[1:0], i_a12};
    end
  end
  assign pins_agree = (cmd_s2_q == cmd_s1_q)
    && (a10_sync_q[2] == a10_sync_q[1])
    && (a12_sync_q[2] == a12_sync_q[1]);
  wire take = ce && pins_agree;
  //==========================================================
  // Command decode, sampled on CK rise
  wire is_rd = take && (cmd_s2_q == `DDRRT_CMD_RD);
  wire is_wr = take && (cmd_s2_q == `DDRRT_CMD_WR);
  wire is_act = take && (cmd_s2_q == `DDRRT_CMD_ACT);
  wire is_pre = take && (cmd_s2_q == `DDRRT_CMD_PRE);
  reg chop;
  always @* begin
    case (i_bl_mode)
      `DDRRT_BL_FIX8: chop = 1'b0;
      `DDRRT_BL_OTF: chop = !a12_sync_q[2];
      `DDRRT_BL_FIX4: chop = 1'b1;
      default: chop = 1'b0;
    endcase
  end
  wire [3:0] beats = chop ? `DDRRT_BEATS4 : `DDRRT_BEATS8;
  //==========================================================
  // Read-to-precharge delay
  reg [5:0] rtp_prog;
  always @* begin
    case (i_rtp_code)
      `DDRRT_WR_001: rtp_prog = `DDRRT_WR_001_NCK;
      default: rtp_prog = `DDRRT_WR_001_NCK;
    endcase
  end
  localparam integer RTP_MIN_I = (`DDRRT_RTP_MIN_NCK > `DDRRT_RTP_NS_CYC) ?
    `DDRRT_RTP_MIN_NCK : `DDRRT_RTP_NS_CYC;
  wire [5:0] rtp_min = RTP_MIN_I[5:0];
  wire [5:0] rtp_eff = (rtp_prog > rtp_min) ? rtp_prog : rtp_min;
  wire [7:0] rd2pre = {2'b00, i_al} + {2'b00, rtp_eff};
  //==========================================================
  // Bank timers
  reg [7:0] ras_cnt_q;
  reg [7:0] rc_cnt_q;
  reg [7:0] rp_cnt_q;
  reg [7:0] rtp_cnt_q;
  reg ap_pend_q;
  wire tras_met = (ras_cnt_q <= 8'h01);
  wire rtp_met = (rtp_cnt_q <= 8'h01);
  wire ap_go = ap_pend_q && rtp_met && tras_met;
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ras_cnt_q <= 8'h00;
      rc_cnt_q <= 8'h00;
      rp_cnt_q <= 8'h00;
      rtp_cnt_q <= 8'h00;
      ap_pend_q <= 1'b0;
      o_bank_open <= 1'b0;
      o_precharging <= 1'b0;
      o_act_ok <= 1'b0;
      o_pre_ok <= 1'b0;
      o_burst_chop <= 1'b0;
      o_auto_pre <= 1'b0;
    end else if (ce) begin
      if (ras_cnt_q != 8'h00)
        ras_cnt_q <= ras_cnt_q - 8'h01;
      if (rc_cnt_q != 8'h00)
        rc_cnt_q <= rc_cnt_q - 8'h01;
      if (rp_cnt_q != 8'h00)
        rp_cnt_q <= rp_cnt_q - 8'h01;
      if (rtp_cnt_q != 8'h00)
        rtp_cnt_q <= rtp_cnt_q - 8'h01;
      if (rp_cnt_q <= 8'h01)
        o_precharging <= 1'b0;
      if (is_act) begin
        o_bank_open <= 1'b1;
        ras_cnt_q <= i_tras;
        rc_cnt_q <= i_trc;
      end
      if (is_rd || is_wr)
        o_burst_chop <= chop;
      if (is_rd) begin
        rtp_cnt_q <= rd2pre;
        ap_pend_q <= a10_sync_q[2];
        o_auto_pre <= a10_sync_q[2];
      end
      if (is_pre || ap_go) begin
        o_bank_open <= 1'b0;
        o_precharging <= 1'b1;
        rp_cnt_q <= i_trp;
        ap_pend_q <= 1'b0;
      end
      o_pre_ok <= o_bank_open && !is_rd && !is_pre && !ap_go
        && !ap_pend_q && rtp_met && tras_met;
      o_act_ok <= !o_bank_open && !is_act && (rp_cnt_q <= 8'h01)
        && (rc_cnt_q <= 8'h01);
    end
  end
  //==========================================================
  // Data windows
  wire rd_fire;
  wire wr_fire;
  reg [3:0] rd_beats_q;
  reg [3:0] wr_beats_q;
  reg [3:0] rd_len_q;
  reg [3:0] wr_len_q;
  wire [7:0] rl = {2'b00, i_cl} + {2'b00, i_al};
  wire [7:0] wl = {2'b00, i_cwl} + {2'b00, i_al};
  ddrrt_delay u_rd_lat (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(ce),
    .i_start(is_rd),
    .i_count(rl),
    .o_fire(rd_fire),
    .o_busy()
  );
  ddrrt_delay u_wr_lat (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(ce),
    .i_start(is_wr),
    .i_count(wl),
    .o_fire(wr_fire),
    .o_busy()
  );
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_beats_q <= 4'h0;
      wr_beats_q <= 4'h0;
      rd_len_q <= 4'h0;
      wr_len_q <= 4'h0;
      o_rd_data_valid <= 1'b0;
      o_wr_data_expect <= 1'b0;
    end else begin
      if (is_rd)
        rd_len_q <= beats;
      if (is_wr)
        wr_len_q <= beats;
      if (rd_fire)
        rd_beats_q <= rd_len_q;
      else if (ce && rd_beats_q > 4'h1)
        rd_beats_q <= rd_beats_q - 4'h2;
      else if (ce)
        rd_beats_q <= 4'h0;
      if (wr_fire)
        wr_beats_q <= wr_len_q;
      else if (ce && wr_beats_q > 4'h1)
        wr_beats_q <= wr_beats_q - 4'h2;
      else if (ce)
        wr_beats_q <= 4'h0;
      o_rd_data_valid <= rd_fire || (rd_beats_q > 4'h2)
        || (!ce && rd_beats_q != 4'h0);
      o_wr_data_expect <= wr_fire || (wr_beats_q > 4'h2)
        || (!ce && wr_beats_q != 4'h0);
    end
  end
endmodule

// File: verification/ddrrt_checker.sv
// Checker of bank state and burst windows of the timing core
module ddrrt_checker (
  input wire i_clk,
  input wire i_sys_rst,
  input wire [1:0] i_bl_mode,
  input wire o_bank_open,
  input wire o_precharging,
  input wire o_act_ok,
  input wire o_pre_ok,
  input wire o_rd_data_valid,
  input wire o_wr_data_expect,
  input wire o_burst_chop
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  //==========================================================
  // Assertions
  property p_act_pre; o_precharging |-> !o_act_ok; endproperty
  a_act_pre: assert property (p_act_pre) else $error("act in pre");
  property p_pre_cl; o_precharging |-> !o_bank_open; endproperty
  a_pre_cl: assert property (p_pre_cl) else $error("open in pre");
  property p_pre_st; $rose(o_precharging) |-> $past(o_bank_open); endproperty
  a_pre_st: assert property (p_pre_st) else $error("pre closed");
  property p_act_cl; o_act_ok |-> !o_bank_open; endproperty
  a_act_cl: assert property (p_act_cl) else $error("act open");
  property p_pre_open; o_pre_ok |-> o_bank_open; endproperty
  a_pre_open: assert property (p_pre_open) else $error("pre shut");
  property p_bl8_rd; $rose(o_rd_data_valid) && !o_burst_chop |->
    o_rd_data_valid[*8] ##[22:26] !o_rd_data_valid; endproperty
  a_bl8_rd: assert property (p_bl8_rd) else $error("bl8 len");
  property p_bc4_rd; $rose(o_rd_data_valid) && o_burst_chop |->
    o_rd_data_valid[*8] ##[6:10] !o_rd_data_valid; endproperty
  a_bc4_rd: assert property (p_bc4_rd) else $error("bc4 len");
  property p_bc4_wr; $rose(o_wr_data_expect) && o_burst_chop |->
    o_wr_data_expect[*8] ##[6:10] !o_wr_data_expect; endproperty
  a_bc4_wr: assert property (p_bc4_wr) else $error("bc4 wr");
  property p_fix4;
    $rose(o_rd_data_valid) && i_bl_mode == 2'h2 |-> o_burst_chop; endproperty
  a_fix4: assert property (p_fix4) else $error("fix4");
  property p_fix8;
    $rose(o_rd_data_valid) && i_bl_mode == 2'h0 |-> !o_burst_chop; endproperty
  a_fix8: assert property (p_fix8) else $error("fix8");
endmodule
bind ddrrt_core ddrrt_checker u_chk (.i_clk, .i_sys_rst, .i_bl_mode,
  .o_bank_open, .o_precharging, .o_act_ok, .o_pre_ok, .o_rd_data_valid,
  .o_wr_data_expect, .o_burst_chop);

// File: verification/ddrrt_ctl_model.sv
// Controller model driving the DRAM clock and command pins
module ddrrt_ctl_model (
  output logic o_ck = 1'b0,
  output logic [2:0] o_cmd = 3'h0,
  output logic o_a10 = 1'b0,
  output logic o_a12 = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  int ck_n = 0;
  //==========================================================
  // Free running clock and command driver
  always #200 o_ck = ~o_ck;
  always @(posedge o_ck) ck_n <= ck_n + 1;
  // Caller keeps command spacing
  task automatic issue(input logic [2:0] c, input logic a, input logic b,
    output int t);
    @(negedge o_ck);
    o_cmd = c;
    o_a10 = a;
    o_a12 = b;
    @(posedge o_ck);
    #1 t = ck_n;
    @(negedge o_ck);
    o_cmd = 3'h0;
    o_a10 = ~a;
    o_a12 = ~b;
  endtask
endmodule

// File: verification/tb_ddrrt_core.sv
// Testbench of the read turnaround timing core
module tb_ddrrt_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0;
  logic i_sys_rst = 1;
  logic [1:0] bl = 0;
  logic [5:0] al = 0;
  logic [7:0] tras = 2;
  wire ck, a10, a12, bo, pg, aok, pok, rv, wv, bc, ap;
  wire [2:0] cmd;
  int n_fail = 0;
  int total_checks = 0;
  always #25 i_clk = ~i_clk;
  ddrrt_ctl_model ctl (.o_ck(ck), .o_cmd(cmd), .o_a10(a10), .o_a12(a12));
  ddrrt_core uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ck(ck),
    .i_cmd(cmd), .i_a10(a10), .i_a12(a12), .i_bl_mode(bl),
    .i_rtp_code(3'h1), .i_cl(6'h05), .i_al(al),
    .i_cwl(6'h04),
    .i_tras(tras), .i_trp(8'h03), .i_trc(8'h04), .o_bank_open(bo),
    .o_precharging(pg), .o_act_ok(aok), .o_pre_ok(pok),
    .o_rd_data_valid(rv), .o_wr_data_expect(wv), .o_burst_chop(bc),
    .o_auto_pre(ap));
  //==========================================================
  // Tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic sel(input int w);
    return w == 0 ? pg : w == 1 ? aok : w == 2 ? rv : w == 3 ? wv : pok;
  endfunction
  task wt(input int w, input logic v, output int t);
    int i;
    for (i = 0; i < 4000 && sel(w) !== v; i++) begin
      @(posedge i_clk);
      #1;
    end
    chk(i < 4000, 1);
    t = ctl.ck_n;
  endtask
  task run(input logic [1:0] m, input logic z, input logic [5:0] l,
    input logic [7:0] r, input logic a);
    int ta, tw, tr, tp, t1, t2, e;
    logic c;
    @(posedge i_clk);
    #1 bl = m;
    al = l;
    tras = r;
    c = m == 2'h2 || (m == 2'h1 && !z);
    ctl.issue(3'h1, 0, z, ta);
    ctl.issue(3'h3, 0, z, tw);
    wt(3, 1, t1);
    chk(t1 - tw, l + 4);
    chk({bc, bo, aok}, {c, 2'b10});
    wt(3, 0, t1);
    ctl.issue(3'h2, a, z, tr);
    e = ta + int'(r) - tr;
    if (int'(l) + 6 > e)
      e = int'(l) + 6;
    wt(2, 1, t1);
    chk(t1 - tr, l + 5);
    chk({bc, ap}, {c, a});
    wt(a ? 0 : 4, 1, t1);
    chk(t1 - tr, e);
    chk({bo, pg}, {~a, a});
    if (!a) begin
      ctl.issue(3'h4, 0, z, tp);
      wt(0, 1, t1);
      chk(t1 - tp, 0);
    end
    wt(1, 1, t2);
    chk(t2 - t1, 3);
    $display("run done mode %0d a12 %0d", m, z);
  endtask
  task close_out;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  //==========================================================
  // Sequence and watchdog
  initial begin
    repeat (3) @(posedge i_clk);
    #1 i_sys_rst = 0;
    repeat (4) @(posedge i_clk);
    run(2'h0, 0, 6'h00, 8'h02, 1);
    run(2'h1, 1, 6'h02, 8'h02, 1);
    run(2'h1, 0, 6'h00, 8'h28, 1);
    run(2'h2, 1, 6'h01, 8'h02, 1);
    run(2'h1, 1, 6'h03, 8'h20, 0);
    close_out;
  end
  initial begin
    #1000000;
    n_fail++;
    close_out;
  end
endmodule
